//--- bench/alarm_eval_checker.sv
// port checker for the process alarm evaluator, bound into every instance
// assumes one clock, synchronous active-high reset and one wait state per access
`timescale 1ns/10ps
module alarm_eval_checker #(
  parameter bit HAS_HEATER = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [alarm_eval_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic heater_alarm_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [alarm_eval_pkg::NCH-1:0] aux_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);
  // ----------------------------------------------------------------
  // shadow of the routing bit
  // ----------------------------------------------------------------
  logic gen_r;
  logic gen_nxt;
  always_comb begin
    gen_nxt = gen_r;
    if (psel_in && penable_in && pready_out && pwrite_in && !pslverr_out &&
        paddr_in == alarm_eval_pkg::ADDR_CTRL) begin
      gen_nxt = pwdata_in[0];
    end
  end
  always_ff @(posedge ref_clk_in) begin
    gen_r <= sys_rst_in ? 1'b0 : gen_nxt;
  end
  sequence s_done;
    psel_in && penable_in && pready_out;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  AST_ONE_WAIT: assert property ($rose(penable_in) && psel_in |=> pready_out)
    else $error("ready not one cycle after access start");
  AST_PULSE: assert property (s_done |=> !pready_out)
    else $error("ready longer than one cycle");
  AST_QUALIFIED: assert property (pready_out |-> psel_in && penable_in)
    else $error("ready outside an access");
  AST_RESET_CLEAR: assert property ($fell(sys_rst_in) |-> aux_out == '0 && !pready_out && prdata_out == '0)
    else $error("outputs not clear after reset");
  AST_REFUSED_READ: assert property (s_done ##0 (!pwrite_in && pslverr_out) |-> prdata_out == '0)
    else $error("refused read returned data");
  AST_MISALIGNED: assert property (s_done ##0 (paddr_in[1:0] != 2'h0) |-> pslverr_out)
    else $error("misaligned access accepted");
  AST_BURNOUT_CH0: assert property (s_done ##0 (pwrite_in && paddr_in inside {8'h20, 8'h40} &&
      pwdata_in == 32'h0000000C) |-> pslverr_out)
    else $error("burnout type accepted on a later channel");
  AST_DELAY_MAX: assert property (s_done ##0 (pwrite_in && paddr_in[4:2] inside {3'h3, 3'h4} &&
      pwdata_in > 32'h000003E7) |-> pslverr_out)
    else $error("delay above limit accepted");
  AST_STATUS_RO: assert property (s_done ##0 (pwrite_in && paddr_in == alarm_eval_pkg::ADDR_STATUS)
      |-> pslverr_out)
    else $error("status write accepted");
  AST_HEATER_ROUTE: assert property (HAS_HEATER && !gen_r && !$past(gen_r) && !$past(sys_rst_in)
      |-> aux_out[0] == $past(heater_alarm_in))
    else $error("first output does not follow heater alarm");
  AST_ERR_HOLD: assert property (!pready_out |-> $stable(pslverr_out))
    else $error("error flag moved outside an answer");
  cover property (s_done ##0 pslverr_out);
endmodule

bind process_alarm_evaluator alarm_eval_checker #(.HAS_HEATER(HAS_HEATER)) chk (
  .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .pwdata_in(pwdata_in), .heater_alarm_in(heater_alarm_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .aux_out(aux_out)
);

//--- bench/process_alarm_evaluator_tb_top.sv
// self-checking bench for the process alarm evaluator
// assumes a one-second tick of 10 cycles and the heater variant
`timescale 1ns/10ps
module process_alarm_evaluator_tb_top;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out;
  logic pready_out, pslverr_out;
  logic [2:0] aux_out, rate, rate_t = 3'h0;
  logic signed [15:0] pv, sp, pv_t = 16'sh0000, sp_t = 16'sh0064;
  logic loop_burnout_alarm, heat, lba_t = 1'b0, heat_t = 1'b0;
  int errors = 0;
  int compares = 0;
  process_feed_model feed (.ref_clk_in(ref_clk_in), .pv_tgt_in(pv_t), .sp_tgt_in(sp_t),
    .rate_tgt_in(rate_t), .burnout_tgt_in(lba_t), .heater_tgt_in(heat_t),
    .process_value_out(pv), .set_point_out(sp), .rate_alarm_out(rate),
    .loop_burnout_alarm_out(loop_burnout_alarm), .heater_alarm_out(heat));
  process_alarm_evaluator #(.SEC_CYCLES(10), .HAS_HEATER(1'b1)) DUT (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .process_value_in(pv), .set_point_in(sp),
    .loop_burnout_alarm_in(loop_burnout_alarm), .rate_alarm_in(rate), .heater_alarm_in(heat),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .aux_out(aux_out));
  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask
  // one apb transfer; ready, read data and error are taken at the edge that samples ready
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    int n;
    logic [31:0] rd;
    logic err;
    n = 0;
    @(posedge ref_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge ref_clk_in);
    penable_in <= 1'b1;
    do begin
      @(posedge ref_clk_in);
      n++;
    end while (pready_out !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    check("pslverr", {31'h0, err}, {31'h0, e});
    if (!w && !e) check("prdata", rd, d);
  endtask
  task automatic aux_is(input int ch, input logic v);
    check("aux", {31'h0, aux_out[ch]}, {31'h0, v});
  endtask
  // drive the stimulus of one alarm type: set point for sp types, else process value
  task automatic put(input logic [4:0] code, input logic [15:0] v);
    pv_t <= (code >= 5'h0E) ? 16'sh0000 : v;
    sp_t <= (code >= 5'h0E) ? v : 16'sh0064;
    rate_t <= (code == 5'h0D) ? {3{v[0]}} : 3'h0;
  endtask
  task automatic run_case(input logic [4:0] code, input logic [15:0] h, l, a, b);
    acc(1'b1, 8'h24, {{16{h[15]}}, h}, 1'b0);
    acc(1'b1, 8'h28, {16'h0000, l}, 1'b0);
    put(code, a);
    acc(1'b1, 8'h20, {27'h0, code}, 1'b0);
    wt(8);
    aux_is(1, 1'b0);
    put(code, b);
    wt(8);
    aux_is(1, code != 5'h00);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    acc(1'b0, 8'h20, 32'h2, 1'b0);
    acc(1'b0, 8'h40, 32'h2, 1'b0);
    acc(1'b0, 8'h00, 32'h2, 1'b0);
    acc(1'b0, 8'h24, 32'h0, 1'b0);
    acc(1'b0, 8'h50, 32'h0, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_types;
    run_case(5'h00, 16'h0000, 16'h0000, 16'h0000, 16'h03E8);
    run_case(5'h01, 16'h000A, 16'h0014, 16'h006E, 16'h004F);
    run_case(5'h02, 16'h000A, 16'h0000, 16'h006D, 16'h006E);
    run_case(5'h03, 16'h000A, 16'h0000, 16'h005B, 16'h005A);
    run_case(5'h04, 16'h000A, 16'h0014, 16'h006F, 16'h0050);
    run_case(5'h05, 16'h000A, 16'h0014, 16'h006E, 16'h004F);
    run_case(5'h06, 16'h000A, 16'h0000, 16'h006D, 16'h006E);
    run_case(5'h07, 16'h000A, 16'h0000, 16'h005B, 16'h005A);
    run_case(5'h08, 16'h0032, 16'h0000, 16'h0032, 16'h0033);
    run_case(5'h09, 16'h0032, 16'h0000, 16'h0032, 16'h0031);
    run_case(5'h0A, 16'h0032, 16'h0000, 16'h0032, 16'h0033);
    run_case(5'h0B, 16'h0032, 16'h0000, 16'h0032, 16'h0031);
    run_case(5'h0D, 16'h0000, 16'h0000, 16'h0000, 16'h0001);
    run_case(5'h0E, 16'h0032, 16'h0000, 16'h0032, 16'h0033);
    run_case(5'h0F, 16'h0032, 16'h0000, 16'h0032, 16'h0031);
    $display("test types done");
  endtask
  // delays of 2 s on and 1 s off, with a 10-cycle second
  task automatic t_delay;
    put(5'h08, 16'h0000);
    acc(1'b1, 8'h4C, 32'h3E8, 1'b1);
    acc(1'b1, 8'h4C, 32'h3E7, 1'b0);
    acc(1'b0, 8'h4C, 32'h3E7, 1'b0);
    acc(1'b1, 8'h4C, 32'h2, 1'b0);
    acc(1'b1, 8'h50, 32'h1, 1'b0);
    acc(1'b1, 8'h44, 32'h32, 1'b0);
    acc(1'b1, 8'h40, 32'h8, 1'b0);
    wt(8);
    put(5'h08, 16'h0064);
    wt(18);
    aux_is(2, 1'b0);
    wt(20);
    aux_is(2, 1'b1);
    put(5'h08, 16'h0000);
    wt(8);
    aux_is(2, 1'b1);
    wt(20);
    aux_is(2, 1'b0);
    $display("test delay done");
  endtask
  task automatic t_standby;
    acc(1'b1, 8'h4C, 32'h0, 1'b0);
    acc(1'b1, 8'h50, 32'h0, 1'b0);
    put(5'h06, 16'h0078);
    acc(1'b1, 8'h44, 32'hA, 1'b0);
    acc(1'b1, 8'h40, 32'h6, 1'b0);
    wt(10);
    aux_is(2, 1'b0);
    put(5'h06, 16'h0064);
    wt(6);
    put(5'h06, 16'h0078);
    wt(8);
    aux_is(2, 1'b1);
    sp_t <= 16'sh0065;
    wt(10);
    aux_is(2, 1'b0);
    acc(1'b0, 8'h64, 32'h00050101, 1'b0);
    $display("test standby done");
  endtask
  task automatic t_heater;
    heat_t <= 1'b1;
    wt(4);
    aux_is(0, 1'b1);
    acc(1'b1, 8'h00, 32'h2, 1'b1);
    acc(1'b1, 8'h60, 32'h1, 1'b0);
    acc(1'b0, 8'h60, 32'h1, 1'b0);
    acc(1'b1, 8'h00, 32'hC, 1'b0);
    acc(1'b0, 8'h00, 32'hC, 1'b0);
    heat_t <= 1'b0;
    lba_t <= 1'b1;
    wt(6);
    aux_is(0, 1'b1);
    lba_t <= 1'b0;
    wt(6);
    aux_is(0, 1'b0);
    acc(1'b1, 8'h20, 32'hC, 1'b1);
    acc(1'b1, 8'h40, 32'hC, 1'b1);
    acc(1'b1, 8'h20, 32'h10, 1'b1);
    acc(1'b0, 8'h7C, 32'h0, 1'b1);
    acc(1'b1, 8'h64, 32'h0, 1'b1);
    acc(1'b0, 8'h22, 32'h0, 1'b1);
    acc(1'b0, 8'h34, 32'h0, 1'b1);
    $display("test heater done");
  endtask
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk_in);
    sys_rst_in <= 1'b0;
    t_reset();
    t_types();
    t_delay();
    t_standby();
    t_heater();
    stop_test();
  end
  // the whole run needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    errors++;
    stop_test();
  end
endmodule

//--- bench/process_feed_model.sv
// measurement path model: registers the bench's targets like a sampled front end
// assumes targets change just after a rising edge
`timescale 1ns/10ps
module process_feed_model (
  input wire logic ref_clk_in,
  input wire logic signed [alarm_eval_pkg::DATA_W-1:0] pv_tgt_in,
  input wire logic signed [alarm_eval_pkg::DATA_W-1:0] sp_tgt_in,
  input wire logic [alarm_eval_pkg::NCH-1:0] rate_tgt_in,
  input wire logic burnout_tgt_in,
  input wire logic heater_tgt_in,
  output logic signed [alarm_eval_pkg::DATA_W-1:0] process_value_out,
  output logic signed [alarm_eval_pkg::DATA_W-1:0] set_point_out,
  output logic [alarm_eval_pkg::NCH-1:0] rate_alarm_out,
  output logic loop_burnout_alarm_out,
  output logic heater_alarm_out
);
  // one sample of latency, as a real converter adds
  always_ff @(posedge ref_clk_in) begin
    process_value_out <= pv_tgt_in;
    set_point_out <= sp_tgt_in;
    rate_alarm_out <= rate_tgt_in;
    loop_burnout_alarm_out <= burnout_tgt_in;
    heater_alarm_out <= heater_tgt_in;
  end
endmodule

//--- rtl/process_alarm_evaluator.sv
// alarm evaluation for a process controller: per-channel type select, compare,
// standby suppression, on/off delays and routing onto auxiliary outputs.
// assumes process value, set point and event inputs come from logic on ref_clk_in,
// and an APB master on the same clock.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/10ps

// Functional notes
// - per-channel type code, resets to two
// - on and off delays, 0..999 seconds
// - channel result drives its auxiliary output
// - code 1 alarms outside set-point band
// - code 2 alarms at pv >= sp+threshold
// - code 3 alarms at pv <= sp-threshold
// - code 4 alarms inside set-point band
// - code 5 is code 1 with standby
// - code 6 is code 2 with standby
// - code 7 is code 3 with standby
// - code 8 alarms when pv exceeds threshold
// - code 9 alarms when pv below threshold
// - code 10 is code 8 with standby
// - code 11 is code 9 with standby
// - code 12 accepted on channel one only
// - code 14 alarms when sp above threshold
// - heater variant: channel one defaults heater alarm
// - code 13 takes external change-rate detection
// - code 15 alarms when sp below threshold
// - band codes use separate high, low limits
module process_alarm_evaluator #(
  parameter int unsigned SEC_CYCLES = alarm_eval_pkg::SEC_CYCLES_DEF,
  parameter bit HAS_HEATER = 1'b1
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [alarm_eval_pkg::ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic signed [alarm_eval_pkg::DATA_W-1:0] process_value_in,
  input wire logic signed [alarm_eval_pkg::DATA_W-1:0] set_point_in,
  input wire logic loop_burnout_alarm_in,
  input wire logic [alarm_eval_pkg::NCH-1:0] rate_alarm_in,
  input wire logic heater_alarm_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  output logic [alarm_eval_pkg::NCH-1:0] aux_out
);

  localparam int NCH = alarm_eval_pkg::NCH;
  localparam int DW = alarm_eval_pkg::DATA_W;
  localparam int XW = alarm_eval_pkg::EXT_W;
  localparam int TW = alarm_eval_pkg::TYPE_W;
  localparam int LW = alarm_eval_pkg::DLY_W;

  // ----------------------------------------------------------------
  // register storage, per channel
  // ----------------------------------------------------------------
  logic [TW-1:0] type_r [NCH];
  logic signed [DW-1:0] high_r [NCH];
  logic signed [DW-1:0] low_r [NCH];
  logic [LW-1:0] on_dly_r [NCH];
  logic [LW-1:0] off_dly_r [NCH];
  logic [NCH-1:0] alarm_r;
  logic [NCH-1:0] raw_r;
  logic [NCH-1:0] stby_r;
  logic ch0_general_r;
  logic ch0_general_nxt;

  // ----------------------------------------------------------------
  // apb slave: one wait state, write lands with pready high
  // ----------------------------------------------------------------
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic acc_err;
  logic wr_fire;
  logic [1:0] acc_ch;
  logic [2:0] acc_idx;
  logic acc_in_ch;
  logic [31:0] rd_word;

  localparam int CH_LSB_HI = alarm_eval_pkg::CH_LSB + 1;
  assign acc_ch = paddr_in[CH_LSB_HI:alarm_eval_pkg::CH_LSB];
  assign acc_idx = paddr_in[4:2];
  assign acc_in_ch = (paddr_in[7] == 1'b0) && (int'(acc_ch) < NCH);
  assign wr_fire = psel_in && penable_in && pwrite_in && pready_r && !acc_err;

  always_comb begin
    acc_err = 1'b0;
    rd_word = 32'h0000_0000;
    if (paddr_in[1:0] != 2'h0) begin
      acc_err = 1'b1;
    end else if (acc_in_ch) begin
      unique case (acc_idx)
        alarm_eval_pkg::IDX_TYPE: begin
          rd_word = {{(32-TW){1'b0}}, type_r[acc_ch]};
          if (pwrite_in) begin
            // burnout code only on channel one
            if (pwdata_in[31:TW] != '0 || pwdata_in[TW-1:0] > alarm_eval_pkg::TYPE_LAST) begin
              acc_err = 1'b1;
            end else if (pwdata_in[TW-1:0] == alarm_eval_pkg::TYPE_LOOP_BURNOUT
                         && acc_ch != 2'h0) begin
              acc_err = 1'b1;
            end
            if (HAS_HEATER && acc_ch == 2'h0 && !ch0_general_r) begin
              acc_err = 1'b1;
            end
          end
        end
        alarm_eval_pkg::IDX_HIGH: begin
          rd_word = {{(32-DW){high_r[acc_ch][DW-1]}}, high_r[acc_ch]};
        end
        alarm_eval_pkg::IDX_LOW: begin
          rd_word = {{(32-DW){low_r[acc_ch][DW-1]}}, low_r[acc_ch]};
        end
        alarm_eval_pkg::IDX_ON_DLY, alarm_eval_pkg::IDX_OFF_DLY: begin
          rd_word = (acc_idx == alarm_eval_pkg::IDX_ON_DLY)
                    ? {{(32-LW){1'b0}}, on_dly_r[acc_ch]}
                    : {{(32-LW){1'b0}}, off_dly_r[acc_ch]};
          if (pwrite_in && pwdata_in > {{(32-LW){1'b0}}, alarm_eval_pkg::DLY_MAX}) begin
            acc_err = 1'b1;
          end
        end
        default: begin
          acc_err = 1'b1;
        end
      endcase
    end else if (paddr_in == alarm_eval_pkg::ADDR_CTRL) begin
      rd_word[alarm_eval_pkg::CTRL_CH0_GENERAL] = ch0_general_r;
    end else if (paddr_in == alarm_eval_pkg::ADDR_STATUS) begin
      rd_word[alarm_eval_pkg::ST_ALARM_LSB +: NCH] = alarm_r;
      rd_word[alarm_eval_pkg::ST_RAW_LSB +: NCH] = raw_r;
      rd_word[alarm_eval_pkg::ST_STBY_LSB +: NCH] = stby_r;
      // status is read-only
      if (pwrite_in) begin
        acc_err = 1'b1;
      end
    end else begin
      acc_err = 1'b1;
    end
  end

  always_comb begin
    pready_nxt = psel_in && penable_in && !pready_r;
    pslverr_nxt = pslverr_r;
    prdata_nxt = prdata_r;
    ch0_general_nxt = ch0_general_r;
    if (pready_nxt) begin
      pslverr_nxt = acc_err;
      prdata_nxt = (pwrite_in || acc_err) ? 32'h0000_0000 : rd_word;
    end
    if (wr_fire && paddr_in == alarm_eval_pkg::ADDR_CTRL) begin
      ch0_general_nxt = pwdata_in[alarm_eval_pkg::CTRL_CH0_GENERAL];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ch0_general_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      ch0_general_r <= ch0_general_nxt;
    end
  end

  assign pready_out = pready_r;
  assign pslverr_out = pslverr_r;
  assign prdata_out = prdata_r;

  // ----------------------------------------------------------------
  // one-second enable and set-point change detect
  // ----------------------------------------------------------------
  logic [31:0] sec_cnt_r;
  logic [31:0] sec_cnt_nxt;
  logic sec_tick_r;
  logic sec_tick_nxt;
  logic signed [DW-1:0] sp_prev_r;
  logic sp_seen_r;
  logic sp_change;

  always_comb begin
    sec_tick_nxt = (sec_cnt_r == 32'(SEC_CYCLES - 1));
    sec_cnt_nxt = sec_tick_nxt ? 32'h0000_0000 : sec_cnt_r + 32'h0000_0001;
  end

  // the first sample after reset counts as a change so standby arms at start-up
  assign sp_change = !sp_seen_r || (set_point_in != sp_prev_r);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sec_cnt_r <= 32'h0000_0000;
      sec_tick_r <= 1'b0;
      sp_prev_r <= 16'h0000;
      sp_seen_r <= 1'b0;
    end else begin
      sec_cnt_r <= sec_cnt_nxt;
      sec_tick_r <= sec_tick_nxt;
      sp_prev_r <= set_point_in;
      sp_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // per-channel evaluation
  // ----------------------------------------------------------------
  logic [NCH-1:0] aux_r;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic [TW-1:0] type_nxt;
    logic signed [DW-1:0] high_nxt;
    logic signed [DW-1:0] low_nxt;
    logic [LW-1:0] on_dly_nxt;
    logic [LW-1:0] off_dly_nxt;
    logic [LW-1:0] cnt_r;
    logic [LW-1:0] cnt_nxt;
    logic [LW-1:0] dly_sel;
    logic alarm_nxt;
    logic raw_nxt;
    logic stby_nxt;
    logic aux_nxt;
    logic cmp;
    logic use_stby;
    logic hit;
    logic signed [XW-1:0] pv;
    logic signed [XW-1:0] sp;
    logic signed [XW-1:0] up_lim;
    logic signed [XW-1:0] dn_lim;
    logic signed [XW-1:0] lo_lim;
    logic signed [XW-1:0] thr;

    assign hit = wr_fire && acc_in_ch && (int'(acc_ch) == c);

    always_comb begin
      type_nxt = type_r[c];
      high_nxt = high_r[c];
      low_nxt = low_r[c];
      on_dly_nxt = on_dly_r[c];
      off_dly_nxt = off_dly_r[c];
      // software picks the type per channel
      if (hit && acc_idx == alarm_eval_pkg::IDX_TYPE) begin
        type_nxt = pwdata_in[TW-1:0];
      end
      if (hit && acc_idx == alarm_eval_pkg::IDX_HIGH) begin
        high_nxt = pwdata_in[DW-1:0];
      end
      if (hit && acc_idx == alarm_eval_pkg::IDX_LOW) begin
        low_nxt = pwdata_in[DW-1:0];
      end
      if (hit && acc_idx == alarm_eval_pkg::IDX_ON_DLY) begin
        on_dly_nxt = pwdata_in[LW-1:0];
      end
      if (hit && acc_idx == alarm_eval_pkg::IDX_OFF_DLY) begin
        off_dly_nxt = pwdata_in[LW-1:0];
      end
    end

    always_comb begin
      pv = XW'(process_value_in);
      sp = XW'(set_point_in);
      thr = XW'(high_r[c]);
      up_lim = sp + thr;
      dn_lim = sp - thr;
      lo_lim = sp - XW'(low_r[c]);
      use_stby = 1'b0;
      cmp = 1'b0;
      unique case (type_r[c])
        alarm_eval_pkg::TYPE_BAND_OUT, alarm_eval_pkg::TYPE_BAND_OUT_SB: begin
          cmp = (pv > up_lim) || (pv < lo_lim);
          use_stby = (type_r[c] == alarm_eval_pkg::TYPE_BAND_OUT_SB);
        end
        alarm_eval_pkg::TYPE_DEV_HI, alarm_eval_pkg::TYPE_DEV_HI_SB: begin
          cmp = (pv >= up_lim);
          use_stby = (type_r[c] == alarm_eval_pkg::TYPE_DEV_HI_SB);
        end
        alarm_eval_pkg::TYPE_DEV_LO, alarm_eval_pkg::TYPE_DEV_LO_SB: begin
          cmp = (pv <= dn_lim);
          use_stby = (type_r[c] == alarm_eval_pkg::TYPE_DEV_LO_SB);
        end
        alarm_eval_pkg::TYPE_BAND_IN: begin
          cmp = (pv >= lo_lim) && (pv <= up_lim);
        end
        alarm_eval_pkg::TYPE_ABS_HI, alarm_eval_pkg::TYPE_ABS_HI_SB: begin
          cmp = (pv > thr);
          use_stby = (type_r[c] == alarm_eval_pkg::TYPE_ABS_HI_SB);
        end
        alarm_eval_pkg::TYPE_ABS_LO, alarm_eval_pkg::TYPE_ABS_LO_SB: begin
          cmp = (pv < thr);
          use_stby = (type_r[c] == alarm_eval_pkg::TYPE_ABS_LO_SB);
        end
        alarm_eval_pkg::TYPE_LOOP_BURNOUT: begin
          cmp = (c == 0) && loop_burnout_alarm_in;
        end
        alarm_eval_pkg::TYPE_RATE: begin
          cmp = rate_alarm_in[c];
        end
        alarm_eval_pkg::TYPE_SP_HI: begin
          cmp = (sp > thr);
        end
        alarm_eval_pkg::TYPE_SP_LO: begin
          cmp = (sp < thr);
        end
        // code zero and unused codes stay off
        default: begin
          cmp = 1'b0;
        end
      endcase
    end

    always_comb begin
      // arm on start-up, set-point or type change; release once false
      stby_nxt = sp_change || (hit && acc_idx == alarm_eval_pkg::IDX_TYPE) || (stby_r[c] && cmp);
      raw_nxt = cmp && !(use_stby && stby_r[c]);
      alarm_nxt = alarm_r[c];
      cnt_nxt = cnt_r;
      dly_sel = raw_r[c] ? on_dly_r[c] : off_dly_r[c];
      // timed on and off delays
      // the tick runs free, so a nonzero delay counts one tick more and never falls short
      if (raw_r[c] == alarm_r[c]) begin
        cnt_nxt = '0;
      end else if (dly_sel == '0 || cnt_r > dly_sel) begin
        alarm_nxt = raw_r[c];
        cnt_nxt = '0;
      end else if (sec_tick_r) begin
        cnt_nxt = cnt_r + 10'h001;
      end
      // heater alarm owns channel one by default
      if (c == 0 && HAS_HEATER && !ch0_general_r) begin
        aux_nxt = heater_alarm_in;
      end else begin
        aux_nxt = alarm_r[c];
      end
    end

    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
        type_r[c] <= alarm_eval_pkg::TYPE_RST;
        high_r[c] <= alarm_eval_pkg::THRESH_RST;
        low_r[c] <= alarm_eval_pkg::THRESH_RST;
        on_dly_r[c] <= alarm_eval_pkg::DLY_RST;
        off_dly_r[c] <= alarm_eval_pkg::DLY_RST;
        cnt_r <= alarm_eval_pkg::DLY_RST;
        alarm_r[c] <= 1'b0;
        raw_r[c] <= 1'b0;
        stby_r[c] <= 1'b1;
        aux_r[c] <= 1'b0;
      end else begin
        type_r[c] <= type_nxt;
        high_r[c] <= high_nxt;
        low_r[c] <= low_nxt;
        on_dly_r[c] <= on_dly_nxt;
        off_dly_r[c] <= off_dly_nxt;
        cnt_r <= cnt_nxt;
        alarm_r[c] <= alarm_nxt;
        raw_r[c] <= raw_nxt;
        stby_r[c] <= stby_nxt;
        aux_r[c] <= aux_nxt;
      end
    end
  end

  assign aux_out = aux_r;

endmodule

//--- shared/alarm_eval_pkg.sv
// package of constants for the process alarm evaluator
// assumes a 100 MHz register clock and 16-bit signed process and set-point words
package alarm_eval_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam int DATA_W = 16;
  localparam int EXT_W = 18;
  localparam int TYPE_W = 5;
  localparam int DLY_W = 10;
  localparam int ADDR_W = 8;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam longint CLK_PERIOD_NS = 10;
  localparam longint ONE_SEC_NS = 1000000000;
  localparam int unsigned SEC_CYCLES_DEF = 32'(ONE_SEC_NS / CLK_PERIOD_NS);
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E7;

  // ----------------------------------------------------------------
  // alarm type codes
  // ----------------------------------------------------------------
  localparam logic [TYPE_W-1:0] TYPE_OFF = 5'h00;
  localparam logic [TYPE_W-1:0] TYPE_BAND_OUT = 5'h01;
  localparam logic [TYPE_W-1:0] TYPE_DEV_HI = 5'h02;
  localparam logic [TYPE_W-1:0] TYPE_DEV_LO = 5'h03;
  localparam logic [TYPE_W-1:0] TYPE_BAND_IN = 5'h04;
  localparam logic [TYPE_W-1:0] TYPE_BAND_OUT_SB = 5'h05;
  localparam logic [TYPE_W-1:0] TYPE_DEV_HI_SB = 5'h06;
  localparam logic [TYPE_W-1:0] TYPE_DEV_LO_SB = 5'h07;
  localparam logic [TYPE_W-1:0] TYPE_ABS_HI = 5'h08;
  localparam logic [TYPE_W-1:0] TYPE_ABS_LO = 5'h09;
  localparam logic [TYPE_W-1:0] TYPE_ABS_HI_SB = 5'h0A;
  localparam logic [TYPE_W-1:0] TYPE_ABS_LO_SB = 5'h0B;
  localparam logic [TYPE_W-1:0] TYPE_LOOP_BURNOUT = 5'h0C;
  localparam logic [TYPE_W-1:0] TYPE_RATE = 5'h0D;
  localparam logic [TYPE_W-1:0] TYPE_SP_HI = 5'h0E;
  localparam logic [TYPE_W-1:0] TYPE_SP_LO = 5'h0F;
  localparam logic [TYPE_W-1:0] TYPE_LAST = 5'h0F;
  localparam logic [TYPE_W-1:0] TYPE_RST = TYPE_DEV_HI;

  // ----------------------------------------------------------------
  // register map: channel block at chan*0x20, word index inside it
  // ----------------------------------------------------------------
  localparam int CH_LSB = 5;
  localparam logic [2:0] IDX_TYPE = 3'h0;
  localparam logic [2:0] IDX_HIGH = 3'h1;
  localparam logic [2:0] IDX_LOW = 3'h2;
  localparam logic [2:0] IDX_ON_DLY = 3'h3;
  localparam logic [2:0] IDX_OFF_DLY = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h60;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h64;
  localparam logic [DATA_W-1:0] THRESH_RST = 16'h0000;
  localparam logic [DLY_W-1:0] DLY_RST = 10'h000;

  // ctrl bit: channel 0 drives the general alarm instead of the heater alarm
  localparam int CTRL_CH0_GENERAL = 0;
  // status fields
  localparam int ST_ALARM_LSB = 0;
  localparam int ST_RAW_LSB = 8;
  localparam int ST_STBY_LSB = 16;

endpackage
